// ===== display_ram_address_counter.sv
// display memory write pointer with mirroring, bit order and icon bank
// assumes host interface logic delivers decoded byte strobes in this clock domain
`timescale 1ns/1ps
`include "ram_pointer_defines.svh"

module display_ram_address_counter
    import ram_pointer_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // interface selection straps
    input  wire logic       interface_select_2,
    input  wire logic       interface_select_1,
    input  wire logic       interface_select_0,
    output host_if_t        hostInterface,
    // i2c acknowledge
    input  wire logic       i2c_data_in,
    input  wire logic       ackRequest,
    output logic            i2c_ack_out,
    output logic            i2c_ack_out_en,
    // host byte strobes
    input  wire logic       dataWrite,
    input  wire logic       commandWrite,
    input  wire logic [7:0] hostByte,
    input  wire logic       loadColumn,
    input  wire logic [6:0] columnValue,
    input  wire logic       loadBank,
    input  wire logic [3:0] bankValue,
    // configuration bits
    input  wire logic       verticalMode,
    input  wire logic       bitOrderLsbTop,
    input  wire logic       horizontal_mirror,
    input  wire logic       vertical_mirror,
    input  wire logic       displayAllOn,
    input  wire logic       displayInverse,
    // pointer and memory write port
    output logic [6:0]      ram_write_pointer_col,
    output logic [3:0]      ram_write_pointer_bank,
    output logic            pixelWrite,
    output logic [6:0]      pixelColumn,
    output logic [6:0]      pixelRowBase,
    output logic [7:0]      pixelData,
    // display side
    output logic [6:0]      scanRow,
    output logic            frameStart,
    output logic [1:0]      videoMode
);
    import ram_pointer_pkg::*;

    pointer_state_t state;
    pointer_state_t next_state;

    function automatic logic [7:0] reverse_byte(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++)
            r[i] = b[7 - i];
        return r;
    endfunction

    function automatic logic [6:0] mirror_column(input logic [6:0] c, input logic m);
        return m ? 7'(`COL_LAST - c) : c;
    endfunction

    // first row of a bank, flipped top-to-bottom under vertical mirror except the icon bank
    function automatic logic [6:0] bank_row(input logic [3:0] b, input logic m);
        logic [6:0] top;
        top = 7'({b, 3'h0});
        if (b == `BANK_ICON)
            return `ICON_ROW;
        // the three-row bank lands on the lowest slots when flipped
        if (m && b == `BANK_LAST)
            return `BANK_LAST_MIRROR_ROW;
        return m ? 7'(`MIRROR_TOP_ROW - top) : top;
    endfunction

    assign hostInterface = host_if_t'({interface_select_2, interface_select_1, interface_select_0});

    // acknowledge drives low on its own pad only in i2c modes
    always_comb
    begin
        i2c_ack_out    = 1'b0;
        i2c_ack_out_en = ackRequest && interface_select_2 && !interface_select_0;
    end

    always_comb
    begin
        next_state = state;
        next_state.outWrite = 1'b0;
        if (dataWrite && !commandWrite)
        begin
            next_state.outWrite  = 1'b1;
            next_state.outColumn = mirror_column(state.column, horizontal_mirror);
            next_state.outRow    = bank_row(state.bank, vertical_mirror);
            next_state.outData   = bitOrderLsbTop ? reverse_byte(hostByte) : hostByte;
            if (state.bank == `BANK_ICON)
            begin
                next_state.column = (state.column == `COL_LAST) ? `COL_FIRST : state.column + 7'h01;
            end
            else if (!verticalMode)
            begin
                if (state.column == `COL_LAST)
                begin
                    next_state.column = `COL_FIRST;
                    next_state.bank = (state.bank == `BANK_LAST) ? `BANK_FIRST : state.bank + 4'h1;
                end
                else
                    next_state.column = state.column + 7'h01;
            end
            else
            begin
                if (state.bank >= `BANK_LAST)
                begin
                    next_state.bank = `BANK_FIRST;
                    next_state.column = (state.column == `COL_LAST) ? `COL_FIRST : state.column + 7'h01;
                end
                else
                    next_state.bank = state.bank + 4'h1;
            end
        end
        if (loadColumn)
            next_state.column = columnValue;
        if (loadBank)
            next_state.bank = bankValue;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            state <= '0;
        else
            state <= next_state;
    end

    assign ram_write_pointer_col  = state.column;
    assign ram_write_pointer_bank = state.bank;
    assign pixelWrite   = state.outWrite;
    assign pixelColumn  = state.outColumn;
    assign pixelRowBase = state.outRow;
    assign pixelData    = state.outData;
    assign videoMode    = {displayAllOn, displayInverse};

    display_scan scanner (
        .clock      (clock),
        .rst        (rst),
        .scanRow    (scanRow),
        .frameStart (frameStart)
    );

    sequence lastCellWrite;
        dataWrite && !commandWrite && !loadColumn && !loadBank
            && state.column == `COL_LAST && state.bank == `BANK_LAST;
    endsequence

    chk_wrap_to_origin: assert property (@(posedge clock) disable iff (rst)
        lastCellWrite |=> state.column == `COL_FIRST && state.bank == `BANK_FIRST)
        else $error("pointer did not wrap to origin");

    chk_horiz_step: assert property (@(posedge clock) disable iff (rst)
        dataWrite && !commandWrite && !loadColumn && !loadBank && !verticalMode
            && state.bank < `BANK_LAST && state.column == `COL_LAST
            |=> state.column == `COL_FIRST && state.bank == $past(state.bank) + 4'h1)
        else $error("horizontal wrap wrong");

    chk_vert_step: assert property (@(posedge clock) disable iff (rst)
        dataWrite && !commandWrite && !loadColumn && !loadBank && verticalMode
            && state.bank < `BANK_LAST |=> state.bank == $past(state.bank) + 4'h1
            && state.column == $past(state.column))
        else $error("vertical step wrong");

    chk_icon_bank_held: assert property (@(posedge clock) disable iff (rst)
        dataWrite && !loadBank && state.bank == `BANK_ICON |=> state.bank == `BANK_ICON)
        else $error("icon bank moved");

    chk_no_icon_entry: assert property (@(posedge clock) disable iff (rst)
        state.bank != `BANK_ICON && !loadBank |=> state.bank != `BANK_ICON)
        else $error("auto step reached icon bank");

    chk_command_holds: assert property (@(posedge clock) disable iff (rst)
        !dataWrite && !loadColumn && !loadBank |=> $stable(state.column) && $stable(state.bank))
        else $error("pointer moved without data");

    chk_load_column: assert property (@(posedge clock) disable iff (rst)
        loadColumn |=> state.column == $past(columnValue))
        else $error("column load lost");

    chk_mirror_zero: assert property (@(posedge clock) disable iff (rst)
        dataWrite && !commandWrite && state.column == `COL_FIRST && horizontal_mirror
            |=> pixelWrite && pixelColumn == `COL_LAST)
        else $error("mirror mapping wrong");

    chk_bit_order: assert property (@(posedge clock) disable iff (rst)
        dataWrite && !commandWrite && bitOrderLsbTop |=> pixelData[0] == $past(hostByte[7]))
        else $error("bit order wrong");

    chk_ack_enable: assert property (@(posedge clock) disable iff (rst)
        i2c_ack_out_en |-> ackRequest && (hostInterface == IF_I2C_STD || hostInterface == IF_I2C_FAST))
        else $error("ack driven outside i2c");

    chk_mirror_row: assert property (@(posedge clock) disable iff (rst)
        dataWrite && !commandWrite && vertical_mirror && state.bank == `BANK_FIRST
            |=> pixelWrite && pixelRowBase == `MIRROR_TOP_ROW)
        else $error("vertical mirror row wrong");

    chk_icon_row: assert property (@(posedge clock) disable iff (rst)
        dataWrite && !commandWrite && state.bank == `BANK_ICON |=> pixelWrite && pixelRowBase == `ICON_ROW)
        else $error("icon row wrong");

    chk_plain_column: assert property (@(posedge clock) disable iff (rst)
        dataWrite && !commandWrite && !horizontal_mirror |=> pixelWrite && pixelColumn == $past(state.column))
        else $error("unmirrored column wrong");

endmodule // display_ram_address_counter

// ===== display_ram_address_counter_bench.sv
// self-checking bench for the display memory write pointer
// assumes the design package, design modules and host model compile first
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fail_count++; \
    $display("[ERR] %s expected %0d seen %0d", nm, ex, got); end end

module display_ram_address_counter_bench;
    import ram_pointer_pkg::*;

    logic           clock = 1'b0;
    logic           rst = 1'b1;
    logic [2:0]     straps = 3'h0;
    logic           i2cIn = 1'b0;
    logic           ackRequest = 1'b0;
    logic [5:0]     cfg = 6'h00;
    logic           dataWrite, commandWrite, loadColumn, loadBank, ackOut, ackEn, pixelWrite, frameStart;
    logic [7:0]     hostByte, pixelData, rev;
    logic [6:0]     columnValue, ptrCol, pixelColumn, pixelRowBase, scanRow;
    logic [3:0]     bankValue, ptrBank;
    logic [1:0]     videoMode;
    host_if_t       hostInterface;
    int             fail_count = 0;
    int             samples_checked = 0;
    int             col, bank, scan, eWr, eCol, eRow, eDat, eFrame, seedValue;
    int             plan [6][4] = '{'{99, 7, 0, 5}, '{100, 8, 0, 3}, '{5, 6, 32, 4}, '{101, 7, 32, 3},
                                    '{100, 10, 60, 3}, '{0, 0, 0, 400}};

    // clock never stops, the bench keeps it running throughout
    initial forever #50 clock = ~clock;

    host_model host_inst (.clock(clock), .dataWrite(dataWrite), .commandWrite(commandWrite),
        .hostByte(hostByte), .loadColumn(loadColumn), .columnValue(columnValue), .loadBank(loadBank),
        .bankValue(bankValue));

    display_ram_address_counter display_ram_address_counter_inst (.clock(clock), .rst(rst),
        .interface_select_2(straps[2]), .interface_select_1(straps[1]), .interface_select_0(straps[0]),
        .hostInterface(hostInterface), .i2c_data_in(i2cIn), .ackRequest(ackRequest), .i2c_ack_out(ackOut),
        .i2c_ack_out_en(ackEn), .dataWrite(dataWrite), .commandWrite(commandWrite), .hostByte(hostByte),
        .loadColumn(loadColumn), .columnValue(columnValue), .loadBank(loadBank), .bankValue(bankValue),
        .verticalMode(cfg[5]), .bitOrderLsbTop(cfg[4]), .horizontal_mirror(cfg[3]), .vertical_mirror(cfg[2]),
        .displayAllOn(cfg[1]), .displayInverse(cfg[0]), .ram_write_pointer_col(ptrCol),
        .ram_write_pointer_bank(ptrBank), .pixelWrite(pixelWrite), .pixelColumn(pixelColumn),
        .pixelRowBase(pixelRowBase), .pixelData(pixelData), .scanRow(scanRow), .frameStart(frameStart),
        .videoMode(videoMode));

    // reference model of pointer, write port and scan counter
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            col = 0;
            bank = 0;
            scan = 0;
            eWr = 0;
            eFrame = 0;
        end
        else
        begin
            scan = (scan == 67) ? 0 : scan + 1;
            eFrame = (scan == 0);
            eWr = dataWrite && !commandWrite;
            if (eWr)
            begin
                rev = {<<{hostByte}};
                eCol = cfg[3] ? 101 - col : col;
                eRow = (bank == 10) ? 67 : !cfg[2] ? 8 * bank : (bank == 8) ? 2 : 59 - 8 * bank;
                eDat = cfg[4] ? rev : hostByte;
                if (bank == 10)
                    col = (col == 101) ? 0 : col + 1;
                else if (!cfg[5])
                begin
                    bank = (col == 101) ? ((bank == 8) ? 0 : bank + 1) : bank;
                    col = (col == 101) ? 0 : col + 1;
                end
                else
                begin
                    col = (bank >= 8) ? ((col == 101) ? 0 : col + 1) : col;
                    bank = (bank >= 8) ? 0 : bank + 1;
                end
            end
            if (loadColumn) col = columnValue;
            if (loadBank) bank = bankValue;
        end
    end

    always @(negedge clock)
    begin
        if (!rst)
        begin
            `CHECK("pixelWrite", eWr, pixelWrite)
            if (eWr)
            begin
                `CHECK("pixelColumn", eCol, pixelColumn)
                `CHECK("pixelRowBase", eRow, pixelRowBase)
                `CHECK("pixelData", eDat, pixelData)
            end
            `CHECK("pointerColumn", col, ptrCol)
            `CHECK("pointerBank", bank, ptrBank)
            `CHECK("scanRow", scan, scanRow)
            `CHECK("frameStart", eFrame, frameStart)
            `CHECK("videoMode", cfg[1:0], videoMode)
            `CHECK("hostInterface", straps, hostInterface)
            `CHECK("ackEnable", ackRequest && (straps == 3'h4 || straps == 3'h6), ackEn)
            `CHECK("ackLevel", 0, ackOut)
        end
    end

    task automatic summarize();
    begin
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask

    initial
    begin
        #(100 * 4000);
        fail_count++;
        summarize();
    end

    initial
    begin
        seedValue = $urandom(7405);
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clock);
            straps <= 3'(i >> 1);
            ackRequest <= i[0];
            i2cIn <= 1'($urandom);
        end
        $display("test straps done");
        // wrap corners, icon bank, then a long fill with stray commands
        foreach (plan[k])
        begin
            cfg <= 6'(plan[k][2]);
            host_inst.setPtr(plan[k][0], plan[k][1]);
            for (int n = 0; n < plan[k][3]; n++)
                host_inst.put(8'($urandom), ($urandom % 8) == 0, ($urandom % 16) == 0);
            host_inst.idle();
            $display("test run %0d done", k);
        end
        // random modes changing under traffic
        for (int n = 0; n < 300; n++)
        begin
            cfg <= 6'($urandom);
            if (n % 20 == 0)
                host_inst.setPtr($urandom % 102, ($urandom % 10 == 9) ? 10 : $urandom % 9);
            host_inst.put(8'($urandom), ($urandom % 8) == 0, 1'b0);
        end
        host_inst.idle();
        $display("test random done");
        summarize();
    end
endmodule // display_ram_address_counter_bench

// ===== display_scan.sv
// free running display row scanner, independent of host writes
// assumes one clock and asynchronous active-high reset
`timescale 1ns/1ps
`include "ram_pointer_defines.svh"

module display_scan
    import ram_pointer_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // scan outputs
    output logic [6:0]      scanRow,
    output logic            frameStart
);
    import ram_pointer_pkg::*;

    scan_state_t state;
    scan_state_t next_state;

    // walks all rows forever; nothing from the host bus reaches it
    always_comb
    begin
        next_state = state;
        next_state.frameTick = 1'b0;
        if (state.rowPos == `ROW_LAST)
        begin
            next_state.rowPos = 7'h00;
            next_state.frameTick = 1'b1;
        end
        else
        begin
            next_state.rowPos = state.rowPos + 7'h01;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            state <= '0;
        else
            state <= next_state;
    end

    assign scanRow    = state.rowPos;
    assign frameStart = state.frameTick;

    chk_scan_wraps: assert property (@(posedge clock) disable iff (rst)
        state.rowPos == `ROW_LAST |=> state.rowPos == 7'h00 && frameStart)
        else $error("scan row did not wrap");

endmodule // display_scan

// ===== host_model.sv
// host side model issuing pointer loads, command bytes and data bytes
// assumes the bench clock; signals change only just after a rising edge
`timescale 1ns/1ps

module host_model
(
    // clock
    input  wire logic       clock,
    // byte strobes
    output logic            dataWrite,
    output logic            commandWrite,
    output logic [7:0]      hostByte,
    output logic            loadColumn,
    output logic [6:0]      columnValue,
    output logic            loadBank,
    output logic [3:0]      bankValue
);
    initial {dataWrite, commandWrite, loadColumn, loadBank, hostByte, columnValue, bankValue} = '0;

    // only columns 0..101 and banks 0..8 or 10 are ever loaded
    task automatic setPtr(input int c, input int b);
    begin
        @(posedge clock);
        dataWrite <= 1'b0;
        commandWrite <= 1'b0;
        loadColumn <= 1'b1;
        loadBank <= 1'b1;
        columnValue <= 7'(c % 102);
        bankValue <= 4'((b == 10) ? 10 : b % 9);
        @(posedge clock);
        loadColumn <= 1'b0;
        loadBank <= 1'b0;
    end
    endtask

    // a slow host sometimes leaves an idle cycle before the byte
    task automatic put(input logic [7:0] v, input logic cmd, input logic both);
    begin
        @(posedge clock);
        if ($urandom % 4 == 0)
        begin
            dataWrite <= 1'b0;
            commandWrite <= 1'b0;
            @(posedge clock);
        end
        dataWrite <= !cmd || both;
        commandWrite <= cmd;
        hostByte <= v;
    end
    endtask

    task automatic idle();
    begin
        @(posedge clock);
        dataWrite <= 1'b0;
        commandWrite <= 1'b0;
    end
    endtask
endmodule // host_model

// ===== ram_pointer_defines.svh
// constants for the display memory write pointer block
// assumes inclusion by bare name from the package and design files
`ifndef RAM_POINTER_DEFINES_SVH
`define RAM_POINTER_DEFINES_SVH

`define COL_LAST        7'h65
`define COL_FIRST       7'h00
`define BANK_LAST       4'h8
`define BANK_ICON       4'hA
`define BANK_FIRST      4'h0
`define ROW_LAST        7'h43
`define ICON_ROW        7'h43
`define MIRROR_TOP_ROW  7'h3B
`define BANK_LAST_MIRROR_ROW 7'h02
`define NUM_COLS        102
`define NUM_ROWS        68
`define IF_SPI3         3'h0
`define IF_SPI4         3'h1
`define IF_PAR8080      3'h2
`define IF_PAR6800      3'h3
`define IF_I2C          3'h4
`define IF_SER3         3'h5
`define IF_I2CHS        3'h6
`define IF_SER3B        3'h7

`endif

// ===== ram_pointer_pkg.sv
// types for the display memory write pointer block
// assumes the defines header is on the include path
`include "ram_pointer_defines.svh"

package ram_pointer_pkg;

    typedef enum logic [2:0] {
        IF_SPI_3LINE = 3'h0,
        IF_SPI_4LINE = 3'h1,
        IF_PAR_8080  = 3'h2,
        IF_PAR_6800  = 3'h3,
        IF_I2C_STD   = 3'h4,
        IF_SERIAL_3  = 3'h5,
        IF_I2C_FAST  = 3'h6,
        IF_SERIAL_3B = 3'h7
    } host_if_t;

    typedef struct packed {
        logic [6:0] column;
        logic [3:0] bank;
        logic [6:0] outColumn;
        logic [6:0] outRow;
        logic [7:0] outData;
        logic       outWrite;
    } pointer_state_t;

    typedef struct packed {
        logic [6:0] rowPos;
        logic       frameTick;
    } scan_state_t;

endpackage
